/* core/fwp_ctrl.sv */
/*
  fwp_ctrl: ahb-lite controlled host for word program of a parallel nor flash.
  assumes one ahb master, word accesses only, flash data pins async to hclk.
*/
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module fwp_ctrl
  import fwp_pkg::*;
#(
  parameter int ABORT_CYC = FWP_ABORT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output fwp_pkg::fwp_pins_t fl_pins,
  output logic [FWP_DW-1:0] fl_dq_o,
  output logic fl_dq_oe_n,
  input wire logic [FWP_DW-1:0] fl_dq_i
);
  import fwp_pkg::*;
  // ==========================================================
  // ahb slave
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [2:0] ctrl_op_q;
  logic [FWP_AW-1:0] addr_q;
  logic [FWP_DW-1:0] data_q;
  logic [FWP_DW-1:0] rdata_q;
  logic [7:0] sr_q;
  logic busy_q, err_q, done_q;
  logic go_q;
  wire logic ahb_go = hsel && hready && htrans[1];
  wire logic [7:0] ahb_off = haddr[7:0];
  wire logic ctrl_wr = wr_pend_q && (wr_addr_q == FWP_REG_CTRL);
  wire logic [31:0] stat_word = {21'h00_0000, done_q, err_q, busy_q, sr_q};
  wire logic [31:0] rd_mux =
    (ahb_off == FWP_REG_CTRL) ? {29'h0000_0000, ctrl_op_q} :
    (ahb_off == FWP_REG_ADDR) ? {10'h000, addr_q} :
    (ahb_off == FWP_REG_DATA) ? {16'h0000, data_q} :
    (ahb_off == FWP_REG_STAT) ? stat_word :
    (ahb_off == FWP_REG_RDATA) ? {16'h0000, rdata_q} : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      addr_q <= '0;
      data_q <= '0;
      ctrl_op_q <= 3'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= ahb_go && hwrite;
      if (ahb_go) wr_addr_q <= ahb_off;
      if (ahb_go && !hwrite) hrdata <= rd_mux;
      if (wr_pend_q && wr_addr_q == FWP_REG_ADDR) addr_q <= hwdata[FWP_AW-1:0];
      if (wr_pend_q && wr_addr_q == FWP_REG_DATA) data_q <= hwdata[FWP_DW-1:0];
      if (ctrl_wr && !busy_q) ctrl_op_q <= hwdata[2:0];
    end
  end
  // ==========================================================
  // data pin synchroniser
  logic [FWP_DW-1:0] dq_s1_q, dq_s2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else if (clk_en) begin
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end
  // ==========================================================
  // pin cycle engine
  logic cyc_start_q, cyc_wr_q;
  logic cyc_busy, cyc_done;
  logic ce_n, we_n, oe_n;
  fwp_pin_cycle u_cyc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .start(cyc_start_q),
    .is_write(cyc_wr_q),
    .busy(cyc_busy),
    .done(cyc_done),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );
  // ==========================================================
  // operation sequencer
  typedef enum logic [3:0] {
    S_IDLE, S_W1, S_W2, S_RD, S_CHK, S_RSTLO, S_RSTHI, S_WAIT
  } fwp_st_t;
  fwp_st_t st_q;
  logic [2:0] op_q;
  logic [7:0] cmd1_q, cmd2_q;
  logic two_q, poll_q;
  logic [15:0] cnt_q;
  logic rst_n_q;
  wire logic [2:0] new_op = hwdata[2:0];
  wire logic sr_ready = dq_s2_q[FWP_SR_READY];
  function automatic logic [7:0] op_cmd(input logic [2:0] op);
    unique case (op)
      FWP_OP_PROGRAM: op_cmd = FWP_CMD_PROG_SETUP;
      FWP_OP_SUSPEND: op_cmd = FWP_CMD_SUSPEND;
      FWP_OP_RESUME: op_cmd = FWP_CMD_RESUME;
      FWP_OP_CLEAR: op_cmd = FWP_CMD_CLR_STAT;
      FWP_OP_READ: op_cmd = FWP_CMD_READ_ARRAY;
      default: op_cmd = FWP_CMD_READ_STAT;
    endcase
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      op_q <= 3'h0;
      cmd1_q <= 8'h00;
      cmd2_q <= 8'h00;
      two_q <= 1'b0;
      poll_q <= 1'b0;
      cnt_q <= 16'h0000;
      rst_n_q <= 1'b1;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      sr_q <= 8'h00;
      rdata_q <= '0;
      cyc_start_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      go_q <= 1'b0;
    end else if (clk_en) begin
      cyc_start_q <= 1'b0;
      go_q <= 1'b0;
      unique case (st_q)
        S_IDLE: if (ctrl_wr) begin
          op_q <= new_op;
          busy_q <= 1'b1;
          done_q <= 1'b0;
          if (new_op == FWP_OP_RESET) begin
            rst_n_q <= 1'b0;
            cnt_q <= 16'(FWP_RST_CYC);
            st_q <= S_RSTLO;
          end else begin
            cmd1_q <= op_cmd(new_op);
            // program ends after its data write so a suspend can follow it
            two_q <= (new_op == FWP_OP_PROGRAM) || (new_op == FWP_OP_SUSPEND);
            cmd2_q <= (new_op == FWP_OP_SUSPEND) ? FWP_CMD_READ_STAT : 8'h00;
            poll_q <= (new_op == FWP_OP_SUSPEND) || (new_op == FWP_OP_RESUME)
              || (new_op == FWP_OP_POLL);
            cyc_wr_q <= (new_op != FWP_OP_POLL);
            cyc_start_q <= 1'b1;
            st_q <= (new_op == FWP_OP_POLL) ? S_RD : S_W1;
          end
        end
        S_W1: if (cyc_done) begin
          if (two_q) begin
            cyc_wr_q <= 1'b1;
            cyc_start_q <= 1'b1;
            st_q <= S_W2;
          end else if (poll_q || op_q == FWP_OP_READ) begin
            cyc_wr_q <= 1'b0;
            cyc_start_q <= 1'b1;
            st_q <= S_RD;
          end else begin
            st_q <= S_WAIT;
          end
        end
        S_W2: if (cyc_done && poll_q) begin
          cyc_wr_q <= 1'b0;
          cyc_start_q <= 1'b1;
          st_q <= S_RD;
        end else if (cyc_done) begin
          st_q <= S_WAIT;
        end
        S_RD: if (cyc_done) begin
          go_q <= 1'b1;
          st_q <= S_CHK;
        end
        S_CHK: begin
          if (op_q == FWP_OP_READ) begin
            rdata_q <= dq_s2_q;
            st_q <= S_WAIT;
          end else begin
            sr_q <= dq_s2_q[7:0];
            if (sr_ready || !poll_q) begin
              err_q <= dq_s2_q[FWP_SR_PERR] | dq_s2_q[FWP_SR_VLOW] | dq_s2_q[FWP_SR_LOCK];
              st_q <= S_WAIT;
            end else begin
              cyc_wr_q <= 1'b0;
              cyc_start_q <= 1'b1;
              st_q <= S_RD;
            end
          end
        end
        S_RSTLO: if (cnt_q == 16'h0000) begin
          rst_n_q <= 1'b1;
          cnt_q <= (ABORT_CYC > FWP_RREC_CYC) ? 16'(ABORT_CYC) : 16'(FWP_RREC_CYC);
          st_q <= S_RSTHI;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
        S_RSTHI: if (cnt_q == 16'h0000) begin
          sr_q <= 8'h00;
          err_q <= 1'b0;
          st_q <= S_WAIT;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
        S_WAIT: if (!cyc_busy) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          if (op_q == FWP_OP_CLEAR) err_q <= 1'b0;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // pin outputs, data driven only during writes
  wire logic dq_wr_phase = (st_q == S_W1) || (st_q == S_W2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl_pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1, addr: '0};
      fl_dq_o <= '0;
      fl_dq_oe_n <= 1'b1;
    end else if (clk_en) begin
      fl_pins <= '{ce_n: ce_n, we_n: we_n, oe_n: oe_n, rst_n: rst_n_q, addr: addr_q};
      fl_dq_o <= (st_q == S_W2 && op_q == FWP_OP_PROGRAM) ? data_q :
        {8'h00, (st_q == S_W2) ? cmd2_q : cmd1_q};
      fl_dq_oe_n <= !(dq_wr_phase || cyc_start_q && cyc_wr_q);
    end
  end
endmodule // fwp_ctrl

/* core/fwp_pin_cycle.sv */
/*
  fwp_pin_cycle: one timed write or read cycle on the flash strobes.
  assumes synchronised read data; a start while busy is held until idle.
*/
`timescale 1ns/1ps
module fwp_pin_cycle
  import fwp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic is_write,
  output logic busy,
  output logic done,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  import fwp_pkg::*;
  // ==========================================================
  // sequencer
  typedef enum logic [1:0] {PC_IDLE, PC_LOW, PC_HIGH} fwp_pc_t;
  fwp_pc_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic pend_q;
  wire logic cnt_end = (cnt_q == 8'h00);
  wire logic go = start || pend_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= PC_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      pend_q <= 1'b0;
      done <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else if (clk_en) begin
      done <= 1'b0;
      // a start that arrives during the high phase is kept, not lost
      if (start && (st_q != PC_IDLE)) pend_q <= 1'b1;
      unique case (st_q)
        PC_IDLE: if (go) begin
          pend_q <= 1'b0;
          wr_q <= is_write;
          cnt_q <= is_write ? 8'(FWP_WP_CYC) : 8'(FWP_ACC_CYC);
          ce_n <= 1'b0;
          we_n <= !is_write;
          oe_n <= is_write;
          st_q <= PC_LOW;
        end
        PC_LOW: if (cnt_end) begin
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          done <= 1'b1;
          cnt_q <= 8'(FWP_WPH_CYC);
          st_q <= PC_HIGH;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        PC_HIGH: if (cnt_end) begin
          st_q <= PC_IDLE;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      endcase
    end
  end
  assign busy = (st_q != PC_IDLE) || pend_q;
endmodule // fwp_pin_cycle

/* core/fwp_pkg.sv */
/*
  fwp_pkg: constants and types for the flash word program controller.
  assumes a 250 MHz hclk and an asynchronous parallel nor flash on pins.
*/
package fwp_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] FWP_CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] FWP_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FWP_CMD_READ_STAT = 8'h70;
  localparam logic [7:0] FWP_CMD_CLR_STAT = 8'h50;
  localparam logic [7:0] FWP_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] FWP_CMD_RESUME = 8'hD0;
  // ==========================================================
  // status_reg bit positions
  localparam int FWP_SR_READY = 7;
  localparam int FWP_SR_PSUSP = 2;
  localparam int FWP_SR_PERR = 4;
  localparam int FWP_SR_VLOW = 3;
  localparam int FWP_SR_LOCK = 1;
  // ==========================================================
  // controller registers (byte offsets)
  localparam logic [7:0] FWP_REG_CTRL = 8'h00;
  localparam logic [7:0] FWP_REG_ADDR = 8'h04;
  localparam logic [7:0] FWP_REG_DATA = 8'h08;
  localparam logic [7:0] FWP_REG_STAT = 8'h0C;
  localparam logic [7:0] FWP_REG_RDATA = 8'h10;
  // ctrl opcodes written to ctrl[2:0]; writing starts the operation
  localparam logic [2:0] FWP_OP_PROGRAM = 3'h1;
  localparam logic [2:0] FWP_OP_SUSPEND = 3'h2;
  localparam logic [2:0] FWP_OP_RESUME = 3'h3;
  localparam logic [2:0] FWP_OP_CLEAR = 3'h4;
  localparam logic [2:0] FWP_OP_READ = 3'h5;
  localparam logic [2:0] FWP_OP_RESET = 3'h6;
  localparam logic [2:0] FWP_OP_POLL = 3'h7;
  // stat register bit positions
  localparam int FWP_ST_BUSY = 8;
  localparam int FWP_ST_ERR = 9;
  localparam int FWP_ST_DONE = 10;
  // ==========================================================
  // timing
  localparam int FWP_CLK_MHZ = 250;
  localparam int FWP_WP_NS = 70;        // write pulse width
  localparam int FWP_WPH_NS = 30;       // write pulse high
  localparam int FWP_ACC_NS = 110;      // read access
  localparam int FWP_RST_NS = 100;      // reset_pulse_min
  localparam int FWP_RREC_NS = 150;     // reset high recovery
  localparam int FWP_PRG_ABORT_US = 12; // program_abort_reset_time
  localparam int FWP_WP_CYC = (FWP_WP_NS * FWP_CLK_MHZ + 999) / 1000;
  localparam int FWP_WPH_CYC = (FWP_WPH_NS * FWP_CLK_MHZ + 999) / 1000;
  localparam int FWP_ACC_CYC = (FWP_ACC_NS * FWP_CLK_MHZ + 999) / 1000 + 2;
  localparam int FWP_RST_CYC = (FWP_RST_NS * FWP_CLK_MHZ + 999) / 1000;
  localparam int FWP_RREC_CYC = (FWP_RREC_NS * FWP_CLK_MHZ + 999) / 1000;
  localparam int FWP_ABORT_CYC = FWP_PRG_ABORT_US * FWP_CLK_MHZ;
  localparam int FWP_AW = 22;
  localparam int FWP_DW = 16;
  // ==========================================================
  // pin bundle towards the flash
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic [FWP_AW-1:0] addr;
  } fwp_pins_t;
endpackage

/* testbench/fwp_ctrl_assertions.sv */
/*
  fwp_ctrl_assertions: pin protocol checks on the flash side of fwp_ctrl.
  assumes it is bound to fwp_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module fwp_ctrl_assertions
  import fwp_pkg::*;
#(
  parameter int ABORT_CYC = FWP_ABORT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fwp_pkg::fwp_pins_t fl_pins,
  input wire logic [FWP_DW-1:0] fl_dq_o,
  input wire logic fl_dq_oe_n
);
  import fwp_pkg::*;
  // ==========================================================
  // low-time counters
  logic [7:0] rlo_q, wlo_q;
  wire logic rd_n = fl_pins.ce_n | fl_pins.oe_n;
  wire logic wr_n = fl_pins.ce_n | fl_pins.we_n;
  wire logic [7:0] rlo_d = fl_pins.rst_n ? 8'h00 : rlo_q + 8'(rlo_q != 8'hFF);
  wire logic [7:0] wlo_d = wr_n ? 8'h00 : wlo_q + 8'(wlo_q != 8'hFF);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rlo_q <= 8'h00;
      wlo_q <= 8'h00;
    end else begin
      rlo_q <= rlo_d;
      wlo_q <= wlo_d;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_we; !rd_n |-> fl_pins.we_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("we low in read");
  property p_rd_tog; $fell(rd_n) |-> !rd_n [*8] ##[1:40] rd_n; endproperty
  a_rd_tog: assert property (p_rd_tog) else $error("read not ended");
  property p_wr_len; $rose(wr_n) |-> wlo_q >= FWP_WP_CYC; endproperty
  a_wr_len: assert property (p_wr_len) else $error("short write pulse");
  property p_wr_hold; !wr_n && $past(!wr_n) |-> $stable(fl_pins.addr) && $stable(fl_dq_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("bus moved in write");
  property p_wr_drv; !wr_n |-> !fl_dq_oe_n; endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("data not driven");
  property p_clash; !fl_dq_oe_n |-> fl_pins.oe_n; endproperty
  a_clash: assert property (p_clash) else $error("dq contention");
  property p_rst_len; $rose(fl_pins.rst_n) |-> rlo_q >= FWP_RST_CYC; endproperty
  a_rst_len: assert property (p_rst_len) else $error("short reset pulse");
  property p_rst_quiet; !fl_pins.rst_n |-> fl_pins.ce_n && fl_pins.we_n && fl_pins.oe_n;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("strobe in reset");
  property p_rst_rec; $rose(fl_pins.rst_n) |-> wr_n [*8]; endproperty
  a_rst_rec: assert property (p_rst_rec) else $error("write too soon");
endmodule // fwp_ctrl_assertions
bind fwp_ctrl fwp_ctrl_assertions #(.ABORT_CYC(ABORT_CYC)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .fl_pins(fl_pins), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n));

/* testbench/fwp_flash_model.sv */
/*
  fwp_flash_model: behavioural word program flash with status register.
  assumes the bench resolves dq and drives the supply and fault inputs.
*/
`timescale 1ns/1ps
module fwp_flash_model
  import fwp_pkg::*;
#(
  parameter int PROG_NS = 300
) (
  input wire fwp_pkg::fwp_pins_t pins,
  input wire logic [FWP_DW-1:0] dq_in,
  output logic [FWP_DW-1:0] dq_out,
  input wire logic vpp_low,
  input wire logic locked,
  input wire logic fail
);
  import fwp_pkg::*;
  logic [7:0] sr;
  logic st_mode, setup, busy, susp;
  int rem;
  logic [FWP_DW-1:0] mem [16];
  logic [FWP_DW-1:0] rd_q, last, pd;
  logic [3:0] pa;
  wire logic wr_n = pins.ce_n | pins.we_n;
  wire logic rd_n = pins.ce_n | pins.oe_n;
  initial begin
    sr = 8'h80;
    {st_mode, setup, busy, susp} = 4'h0;
    rd_q = 16'h0000;
    last = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  // ==========================================================
  // command capture at end of write pulse
  always @(posedge wr_n) begin
    if (!pins.rst_n) begin
    end else if (setup) begin
      setup = 1'b0;
      st_mode = 1'b1;
      if (sr[3] || vpp_low) sr[3] = 1'b1;
      else if (locked) sr[1] = 1'b1;
      else begin
        pa = pins.addr[3:0];
        pd = dq_in;
        busy = 1'b1;
        sr[7] = 1'b0;
        rem = PROG_NS / 10;
      end
    end else begin
      case (dq_in[7:0])
        FWP_CMD_PROG_SETUP: setup = 1'b1;
        FWP_CMD_READ_ARRAY: st_mode = 1'b0;
        FWP_CMD_READ_STAT: st_mode = 1'b1;
        FWP_CMD_CLR_STAT: sr = sr & 8'hE5;
        FWP_CMD_SUSPEND: begin
          st_mode = 1'b1;
          if (busy) {susp, sr[2], sr[7]} = 3'b111;
        end
        FWP_CMD_RESUME: begin
          st_mode = 1'b1;
          if (susp) {susp, sr[2], sr[7]} = 3'b000;
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // program timer, reset abort, read output
  always begin
    #10;
    if (busy && !susp) begin
      if (rem > 0) rem = rem - 1;
      else begin
        busy = 1'b0;
        sr[7] = 1'b1;
        if (fail) sr[4] = 1'b1;
        else mem[pa] = pd;
      end
    end
  end
  always @(negedge pins.rst_n) begin
    {st_mode, setup, busy, susp} = 4'h0;
    sr = 8'h80;
  end
  always @(negedge rd_n) rd_q = st_mode ? {8'h00, sr} : mem[pins.addr[3:0]];
  always @(posedge rd_n) last = rd_q;
  assign dq_out = (!rd_n && pins.rst_n) ? rd_q : ~last;
endmodule // fwp_flash_model

/* testbench/tb.sv */
/*
  tb: ahb-lite register tests of fwp_ctrl against a flash model.
  assumes zero-wait slave and the flash model on the pins.
*/
`timescale 1ns/1ps
module tb;
  import fwp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fl_dq_oe_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  fwp_pins_t fl_pins;
  logic [FWP_DW-1:0] fl_dq_o, dq_dev;
  logic vpp_low, locked, fail;
  int fails, checked, cyc;
  wire logic [FWP_DW-1:0] dq_w = fl_dq_oe_n ? dq_dev : fl_dq_o;
  fwp_ctrl #(.ABORT_CYC(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fl_pins(fl_pins), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_i(dq_w));
  fwp_flash_model #(.PROG_NS(1000)) u_flash (.pins(fl_pins), .dq_in(dq_w), .dq_out(dq_dev),
    .vpp_low(vpp_low), .locked(locked), .fail(fail));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ==========================================================
  // tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] c);
    xfer(1'b1, FWP_REG_CTRL, {29'h0, c}, q);
    do xfer(1'b0, FWP_REG_STAT, 32'h0, q); while (q[FWP_ST_BUSY] !== 1'b1);
    do xfer(1'b0, FWP_REG_STAT, 32'h0, q);
    while (q[FWP_ST_BUSY] !== 1'b0 || q[FWP_ST_DONE] !== 1'b1);
  endtask
  task automatic prog(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, FWP_REG_ADDR, a, q);
    xfer(1'b1, FWP_REG_DATA, d, q);
    op(FWP_OP_PROGRAM);
    op(FWP_OP_POLL);
  endtask
  task automatic stat(input logic [31:0] exp);
    xfer(1'b0, FWP_REG_STAT, 32'h0, q);
    chk(q & 32'h0000_07FF, exp);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b1, FWP_REG_ADDR, a, q);
    op(FWP_OP_READ);
    xfer(1'b0, FWP_REG_RDATA, 32'h0, q);
    chk(q, exp);
  endtask
  // ==========================================================
  // timeout and main sequence
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, vpp_low, locked, fail} = 6'h00;
    {haddr, hwdata, htrans, hsize, cyc, fails, checked} = '0;
    hsize = 3'b010;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h0000_0000);
    prog(32'h3, 32'hA5C3);
    stat(32'h0000_0480);
    rd(32'h3, 32'h0000_A5C3);
    $display("test program done");
    locked <= 1'b1;
    prog(32'h5, 32'h5A5A);
    stat(32'h0000_0682);
    locked <= 1'b0;
    prog(32'h6, 32'h1234);
    stat(32'h0000_0682);
    op(FWP_OP_CLEAR);
    op(FWP_OP_POLL);
    stat(32'h0000_0480);
    $display("test lock done");
    vpp_low <= 1'b1;
    prog(32'h7, 32'h1111);
    stat(32'h0000_0688);
    vpp_low <= 1'b0;
    prog(32'h7, 32'h1111);
    stat(32'h0000_0688);
    rd(32'h7, 32'h0000_FFFF);
    op(FWP_OP_CLEAR);
    fail <= 1'b1;
    prog(32'h8, 32'h0F0F);
    stat(32'h0000_0690);
    fail <= 1'b0;
    op(FWP_OP_CLEAR);
    $display("test errors done");
    prog(32'h9, 32'h00C3);
    op(FWP_OP_SUSPEND);
    stat(32'h0000_0480);
    op(FWP_OP_RESUME);
    stat(32'h0000_0480);
    xfer(1'b1, FWP_REG_ADDR, 32'hB, q);
    xfer(1'b1, FWP_REG_DATA, 32'h3C3C, q);
    op(FWP_OP_PROGRAM);
    op(FWP_OP_SUSPEND);
    stat(32'h0000_0484);
    rd(32'h3, 32'h0000_A5C3);
    op(FWP_OP_RESUME);
    stat(32'h0000_0480);
    rd(32'h9, 32'h0000_00C3);
    rd(32'hB, 32'h0000_3C3C);
    xfer(1'b1, FWP_REG_ADDR, 32'hC, q);
    xfer(1'b1, FWP_REG_DATA, 32'h0001, q);
    op(FWP_OP_PROGRAM);
    op(FWP_OP_RESET);
    stat(32'h0000_0400);
    rd(32'hC, 32'h0000_FFFF);
    locked <= 1'b1;
    prog(32'hA, 32'h0001);
    locked <= 1'b0;
    op(FWP_OP_RESET);
    op(FWP_OP_SUSPEND);
    stat(32'h0000_0480);
    $display("test suspend and reset done");
    end_of_test;
  end
endmodule // tb
